// >>> dv/serial_message_receive_store_tb.sv
`timescale 1ns/1ns
module serial_message_receive_store_tb;
	import smrs_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] adr = 8'h00;
	logic rd_r = 1'b0;
	logic wr_r = 1'b0;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] rdat;
	logic wreq;
	logic cv;
	smrs_rx_char_t ch;
	smrs_mem_wr_t mw;
	logic irq;
	smrs_mem_wr_t q[$];
	logic [31:0] seed = 32'h000053a1;
	int miscompares = 0;
	int checks_done = 0;
	logic [15:0] r;

	always #4 clk = ~clk;

	smrs_receive_store #(
		.TIMEOUT_CYCLES(2000)
	) uut (
		.i_sys_clk(clk),
		.i_nrst(nrst),
		.i_avs_address(adr),
		.i_avs_read(rd_r),
		.i_avs_write(wr_r),
		.i_avs_writedata(wdat),
		.i_avs_byteenable(4'hf),
		.o_avs_readdata(rdat),
		.o_avs_waitrequest(wreq),
		.i_char_valid(cv),
		.i_char(ch),
		.o_mem_wr(mw),
		.o_irq(irq)
	);

	smrs_sender snd (
		.i_sys_clk(clk),
		.o_char_valid(cv),
		.o_char(ch)
	);

	// we stays high for one cycle per word, so the falling edge sees each word once
	always @(negedge clk)
		if (mw.we === 1'b1)
			q.push_back(mw);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [15:0] exp_word(input int i, input int n);
		return {snd.msg[2 * i], (2 * i + 1 < n) ? snd.msg[2 * i + 1] : 8'h00};
	endfunction

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task conclude();
		$display("comparisons %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [15:0] d, output logic [15:0] rv);
		@(posedge clk);
		rd_r <= ~w;
		wr_r <= w;
		adr <= a;
		wdat <= {16'h0000, d};
		// waitrequest and read data are taken as they stood at the edge
		do
			@(posedge clk);
		while (wreq !== 1'b0);
		rv = rdat[15:0];
		rd_r <= 1'b0;
		wr_r <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		bus(1'b0, a, 16'h0000, v);
	endtask

	task automatic recv(input logic [15:0] ctl, output logic [15:0] v);
		int t;
		t = 0;
		wr(SMRS_OFS_CTRL, ctl | 16'h0001);
		v = 16'h0000;
		while (v[15:8] === 8'h00 && t < 300)
		begin
			rd(SMRS_OFS_RESULT, v);
			t++;
		end
	endtask

	task automatic fill(input int n);
		for (int i = 0; i < n; i++)
			snd.msg[i] = 8'(rnd());
		q.delete();
	endtask

	task automatic rx_ok(input int n, input logic [15:0] ctl,
		input logic [15:0] st);
		logic [15:0] v;
		int w;
		w = (n + 1) / 2;
		fill(n);
		snd.send(n, int'(rnd() % 3), 3'b000);
		recv(ctl, v);
		chk("result", v, 32'h1000);
		chk("word count", q.size(), w);
		foreach (q[i])
		begin
			chk("address", q[i].addr, st + i);
			chk("data", q[i].data, exp_word(i, n));
		end
		rd(SMRS_OFS_SIZE, v);
		chk("size", v, ctl[SMRS_CTL_BYTES] ? n : w);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (40000) @(posedge clk);
		miscompares++;
		$display("watchdog expired");
		conclude();
	end

	initial
	begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		for (int a = 0; a < 12; a++)
		begin
			rd(8'(a * 4), r);
			chk("reset value", r, 32'h0);
		end
		rd(8'h30, r);
		chk("unmapped", r, 32'h0);
		wr(SMRS_OFS_SIZE, 16'hffff);
		rd(SMRS_OFS_SIZE, r);
		chk("read-only size", r, 32'h0);
		wr(SMRS_OFS_CHAN, 16'h0000);
		wr(SMRS_OFS_RANGE_HI, 16'h7fff);
		wr(SMRS_OFS_IRQ_MASK, 16'h000f);
		$display("test reset done");
		for (int k = 0; k < 8; k++)
		begin
			r = 16'(rnd() % 256);
			wr(SMRS_OFS_START, r);
			rx_ok(k == 0 ? 1 : (k == 1 ? 32 : 1 + int'(rnd() % 32)),
				{13'h0000, k[2], k[0], 1'b0}, r);
		end
		@(negedge clk);
		chk("irq on done", irq, 1'b1);
		rd(SMRS_OFS_IRQ_STAT, r);
		chk("done event", r[0], 1'b1);
		@(negedge clk);
		chk("irq after clear", irq, 1'b0);
		$display("test receive done");
		// line errors; the last pass leaves the buffered variant off
		for (int e = 0; e < 4; e++)
		begin
			fill(4);
			snd.send(4, 0, e < 3 ? 3'b001 << e : 3'b001);
			recv(e < 3 ? 16'h0004 : 16'h0000, r);
			chk("line error", r[15:8], 8'h88);
			chk("no store", q.size(), 0);
			rd(SMRS_OFS_RX_ERR, r);
			chk("status", r, e < 3 ? 32'h8 << e : 32'h0);
		end
		$display("test line errors done");
		wr(SMRS_OFS_START, 16'h0100);
		wr(SMRS_OFS_RANGE_LO, 16'h0100);
		wr(SMRS_OFS_RANGE_HI, 16'h0102);
		rx_ok(6, 16'h0000, 16'h0100);
		fill(8);
		snd.send(8, 0, 3'b000);
		recv(16'h0000, r);
		chk("range error", r, 32'h8200);
		chk("no store", q.size(), 0);
		wr(SMRS_OFS_RANGE_LO, 16'h0000);
		wr(SMRS_OFS_RANGE_HI, 16'h7fff);
		wr(SMRS_OFS_START, 16'h8000);
		recv(16'h0000, r);
		chk("offset error", r, 32'h8200);
		wr(SMRS_OFS_START, 16'h0000);
		fill(33);
		snd.send(33, 0, 3'b000);
		recv(16'h0000, r);
		chk("size error", r[15:8], 8'h83);
		$display("test settings done");
		wr(SMRS_OFS_IRQ_MASK, 16'h0000);
		rd(SMRS_OFS_IRQ_STAT, r);
		fill(2);
		repeat (21) snd.send(2, 0, 3'b000);
		// let the dropped message reach the status register first
		repeat (3) @(negedge clk);
		chk("irq masked", irq, 1'b0);
		wr(SMRS_OFS_IRQ_MASK, 16'h0004);
		@(negedge clk);
		chk("irq unmasked", irq, 1'b1);
		rd(SMRS_OFS_IRQ_STAT, r);
		chk("full event", r[2], 1'b1);
		@(negedge clk);
		chk("irq cleared", irq, 1'b0);
		for (int j = 0; j < 20; j++)
		begin
			recv(16'h0004, r);
			chk("drain result", r[15:8], 8'h10);
			if (j == 0)
			begin
				rd(SMRS_OFS_RX_ERR, r);
				chk("full status", r, 32'h1);
			end
		end
		rd(SMRS_OFS_RSVD_B, r);
		chk("buffers left", r, 32'h0);
		$display("test buffer full done");
		rd(SMRS_OFS_IRQ_STAT, r);
		snd.send(2, 1, 3'b000);
		// the timeout count is a parameter of this instance
		repeat (2100) @(posedge clk);
		rd(SMRS_OFS_IRQ_STAT, r);
		chk("discard event", r[3], 1'b1);
		fill(2);
		snd.send(2, 0, 3'b000);
		recv(16'h0004, r);
		rd(SMRS_OFS_RX_ERR, r);
		chk("discard status", r, 32'h2);
		$display("test timeout done");
		conclude();
	end
endmodule

// >>> dv/smrs_properties.sv
`timescale 1ns/1ns
module smrs_properties
	import smrs_pkg::*;
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// register bus
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	// memory write port
	input wire smrs_mem_wr_t o_mem_wr
);
	logic [15:0] start_reg;
	logic [15:0] lo_reg;
	logic [15:0] hi_reg;
	logic fd_reg;
	wire req = i_avs_read || i_avs_write;
	wire wr_done = i_avs_write && !o_avs_waitrequest;
	wire rd_done = i_avs_read && !o_avs_waitrequest;
	wire [15:0] rd16 = o_avs_readdata[15:0];
	wire [15:0] wd16 = i_avs_writedata[15:0];

	////////////////////////////////////////////////////////////////////////
	// shadow of the settings; assumes full byte enables from software
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			start_reg <= 16'h0000;
			lo_reg <= 16'h0000;
			hi_reg <= 16'h0000;
			fd_reg <= 1'b0;
		end
		else if (wr_done)
		begin
			if (i_avs_address == SMRS_OFS_START)
				start_reg <= wd16;
			if (i_avs_address == SMRS_OFS_RANGE_LO)
				lo_reg <= wd16;
			if (i_avs_address == SMRS_OFS_RANGE_HI)
				hi_reg <= wd16;
			if (i_avs_address == SMRS_OFS_CTRL)
				fd_reg <= wd16[SMRS_CTL_FD];
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);

	a_wait_first: assert property ($rose(req) |-> o_avs_waitrequest)
		else $error("waitrequest low in first access cycle");
	a_wait_one: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("access not answered in the second cycle");
	a_upper_zero: assert property (rd_done |-> o_avs_readdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	a_err_gate: assert property (rd_done && !fd_reg &&
		i_avs_address == SMRS_OFS_RX_ERR |-> rd16 == 16'h0000)
		else $error("error status visible without buffered variant");
	a_err_bits: assert property (rd_done &&
		i_avs_address == SMRS_OFS_RX_ERR |-> (rd16 & 16'hffc4) == 16'h0000)
		else $error("undefined error status bit set");
	a_result_code: assert property (rd_done &&
		i_avs_address == SMRS_OFS_RESULT |->
		rd16[15:8] inside {8'h00, 8'h10, 8'h82, 8'h83, 8'h88})
		else $error("result upper byte not a defined code");
	a_first_addr: assert property (o_mem_wr.we && !$past(o_mem_wr.we)
		|-> o_mem_wr.addr == start_reg)
		else $error("first stored word not at start offset");
	a_in_range: assert property (o_mem_wr.we |->
		o_mem_wr.addr >= lo_reg && o_mem_wr.addr <= hi_reg)
		else $error("memory write outside write range");
	a_addr_step: assert property (o_mem_wr.we && $past(o_mem_wr.we)
		|-> o_mem_wr.addr == $past(o_mem_wr.addr) + 16'h0001)
		else $error("memory writes not consecutive");
endmodule

bind smrs_receive_store smrs_properties u_props (
	.i_sys_clk(i_sys_clk),
	.i_nrst(i_nrst),
	.i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read),
	.i_avs_write(i_avs_write),
	.i_avs_writedata(i_avs_writedata),
	.o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest),
	.o_mem_wr(o_mem_wr)
);

// >>> dv/smrs_sender.sv
`timescale 1ns/1ns
module smrs_sender
	import smrs_pkg::*;
(
	// clock
	input wire logic i_sys_clk,
	// characters towards the receiver
	output logic o_char_valid,
	output smrs_rx_char_t o_char
);
	logic [7:0] msg [0:63];

	initial
	begin
		o_char_valid = 1'b0;
		o_char = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// line errors flag the last character; idle data in gaps is inverted, and the
	// closing toggle puts the last byte back on the line after a message with gaps
	task automatic send(input int n, input int gap, input logic [2:0] err);
		logic l;
		for (int i = 0; i < n; i++)
		begin
			l = (i == n - 1);
			@(posedge i_sys_clk);
			o_char_valid <= 1'b1;
			o_char <= {msg[i], l & err[0], l & err[1], l & err[2], l};
			repeat (gap)
			begin
				@(posedge i_sys_clk);
				o_char_valid <= 1'b0;
				o_char.data <= ~msg[i];
			end
		end
		@(posedge i_sys_clk);
		o_char_valid <= 1'b0;
		o_char.data <= ~o_char.data;
	endtask
endmodule

// >>> rtl/smrs_msg_assembler.sv
`timescale 1ns/1ns
module smrs_msg_assembler
	import smrs_pkg::*;
	#(parameter int MSG_BYTES = SMRS_MSG_BYTES)
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// characters from the line receiver
	input wire logic i_char_valid,
	input wire smrs_rx_char_t i_char,
	input wire logic i_slot_free,
	// words into the receive buffer
	output logic o_word_we,
	output logic [SMRS_WIDX_W-1:0] o_word_idx,
	output logic [15:0] o_word_data,
	// message events
	output logic o_msg_done,
	output smrs_msg_info_t o_msg_info,
	output logic o_full_drop
);

	logic in_msg_reg;
	logic drop_reg;
	logic [SMRS_CNT_W-1:0] cnt_reg;
	logic [7:0] hi_reg;
	smrs_msg_info_t info_reg;

	wire first = i_char_valid & ~in_msg_reg;
	wire dropping = first ? ~i_slot_free : drop_reg;
	wire [SMRS_CNT_W-1:0] cnt_now = first ? '0 : cnt_reg;
	wire fits = cnt_now < SMRS_CNT_W'(MSG_BYTES);
	wire store = i_char_valid & ~dropping & fits;

	smrs_msg_info_t info_now;
	smrs_msg_info_t info_next;
	assign info_now = first ? '0 : info_reg;
	assign info_next.nbytes = store ? cnt_now + 1'b1 : cnt_now;
	assign info_next.par_err = info_now.par_err | i_char.par_err;
	assign info_next.frm_err = info_now.frm_err | i_char.frm_err;
	assign info_next.ovr_err = info_now.ovr_err | i_char.ovr_err;
	assign info_next.too_long = info_now.too_long | ~fits;

	////////////////////////////////////////////////////////////////////////
	// a whole message is refused when no buffer is free at its first byte
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			in_msg_reg <= 1'b0;
			drop_reg <= 1'b0;
			cnt_reg <= '0;
			info_reg <= '0;
		end
		else if (i_char_valid)
		begin
			in_msg_reg <= ~i_char.eom;
			drop_reg <= dropping;
			cnt_reg <= info_next.nbytes;
			info_reg <= info_next;
		end
	end

	// even bytes are written with the low half zero, then overwritten unless the message ends on them
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			hi_reg <= 8'h00;
			o_word_we <= 1'b0;
			o_word_idx <= '0;
			o_word_data <= 16'h0000;
			o_msg_done <= 1'b0;
			o_msg_info <= '0;
			o_full_drop <= 1'b0;
		end
		else
		begin
			o_word_we <= store;
			o_msg_done <= i_char_valid & i_char.eom & ~dropping;
			o_full_drop <= i_char_valid & i_char.eom & dropping;
			if (store)
			begin
				o_word_idx <= cnt_now[SMRS_WIDX_W:1];
				o_word_data <= cnt_now[0] ? {hi_reg, i_char.data}
					: {i_char.data, 8'h00};
				if (!cnt_now[0])
					hi_reg <= i_char.data;
			end
			if (i_char_valid & i_char.eom)
				o_msg_info <= info_next;
		end
	end

endmodule

// >>> rtl/smrs_pkg.sv
package smrs_pkg;

	////////////////////////////////////////////////////////////////////////
	// sizes and timing
	localparam int SMRS_NUM_BUFS = 20;
	localparam int SMRS_MSG_BYTES = 32;
	localparam int SMRS_PTR_W = 5;
	localparam int SMRS_CNT_W = 6;
	localparam int SMRS_WIDX_W = 4;
	localparam int SMRS_CLK_KHZ = 125000;
	localparam int SMRS_TIMEOUT_MS = 400;
	localparam int SMRS_TIMEOUT_CYC = SMRS_TIMEOUT_MS * SMRS_CLK_KHZ;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] SMRS_OFS_CTRL = 8'h00;
	localparam logic [7:0] SMRS_OFS_RESULT = 8'h04;
	localparam logic [7:0] SMRS_OFS_RX_ERR = 8'h08;
	localparam logic [7:0] SMRS_OFS_SIZE = 8'h0c;
	localparam logic [7:0] SMRS_OFS_START = 8'h10;
	localparam logic [7:0] SMRS_OFS_RANGE_LO = 8'h14;
	localparam logic [7:0] SMRS_OFS_RANGE_HI = 8'h18;
	localparam logic [7:0] SMRS_OFS_CHAN = 8'h1c;
	localparam logic [7:0] SMRS_OFS_RSVD_A = 8'h20;
	localparam logic [7:0] SMRS_OFS_RSVD_B = 8'h24;
	localparam logic [7:0] SMRS_OFS_IRQ_STAT = 8'h28;
	localparam logic [7:0] SMRS_OFS_IRQ_MASK = 8'h2c;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int SMRS_CTL_START = 0;
	localparam int SMRS_CTL_BYTES = 1;
	localparam int SMRS_CTL_FD = 2;
	localparam int SMRS_ST_FULL = 0;
	localparam int SMRS_ST_DISC = 1;
	localparam int SMRS_ST_PAR = 3;
	localparam int SMRS_ST_FRM = 4;
	localparam int SMRS_ST_OVR = 5;
	localparam int SMRS_IRQ_DONE = 0;
	localparam int SMRS_IRQ_ERR = 1;
	localparam int SMRS_IRQ_FULL = 2;
	localparam int SMRS_IRQ_DISC = 3;

	////////////////////////////////////////////////////////////////////////
	// result codes (upper byte of the result word) and reset values
	localparam logic [7:0] SMRS_RES_BUSY = 8'h00;
	localparam logic [7:0] SMRS_RES_DONE = 8'h10;
	localparam logic [7:0] SMRS_RES_ADDR_ERR = 8'h82;
	localparam logic [7:0] SMRS_RES_SIZE_ERR = 8'h83;
	localparam logic [7:0] SMRS_RES_LINE_ERR = 8'h88;
	localparam logic [15:0] SMRS_RESULT_RST = 16'h0000;
	localparam logic [15:0] SMRS_REG_RST = 16'h0000;
	localparam logic [3:0] SMRS_IRQ_RST = 4'h0;

	////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic [7:0] data;
		logic par_err;
		logic frm_err;
		logic ovr_err;
		logic eom;
	} smrs_rx_char_t;

	typedef struct packed {
		logic [SMRS_CNT_W-1:0] nbytes;
		logic par_err;
		logic frm_err;
		logic ovr_err;
		logic too_long;
	} smrs_msg_info_t;

	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [15:0] data;
	} smrs_mem_wr_t;

endpackage

// >>> rtl/smrs_receive_store.sv
// Function
// - error status word reads nonzero only with buffered variant selected.
// - all 20 buffers occupied sets status bit 0; incoming message lost.
// - message unread 400 ms is discarded; status bit 1 set.
// - parity error sets status bit 3; message not stored.
// - framing error sets status bit 4; message not stored.
// - overrun sets status bit 5; message not stored.
// - size reported in words, or in bytes in second mode.
// - words stored consecutively from programmed start offset.
// - range limits are word addresses; outside write errors, nothing written.
// - channel holder keeps current buffer; program clears it once.
// - result upper byte 00 busy, 10 complete, 8y on error.
// - result 82 when start offset is out of range.
// - result 83 when received size is out of range.
`timescale 1ns/1ns
module smrs_receive_store
	import smrs_pkg::*;
	#(
	parameter int TIMEOUT_CYCLES = SMRS_TIMEOUT_CYC,
	parameter int MSG_BYTES = SMRS_MSG_BYTES,
	parameter logic [15:0] MEM_MAX_ADDR = 16'h7fff
	)
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// avalon-mm slave
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// received characters
	input wire logic i_char_valid,
	input wire smrs_rx_char_t i_char,
	// word memory write port
	output smrs_mem_wr_t o_mem_wr,
	// interrupt
	output logic o_irq
);

	localparam int MSG_WORDS = MSG_BYTES / 2;

	function automatic logic [SMRS_PTR_W-1:0] next_ptr(
		input logic [SMRS_PTR_W-1:0] p);
		next_ptr = (p == SMRS_PTR_W'(SMRS_NUM_BUFS - 1)) ? '0 : p + 1'b1;
	endfunction

	function automatic logic [15:0] be_merge(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CHECK, ST_WRITE} smrs_st_t;

	////////////////////////////////////////////////////////////////////////
	// receive buffers
	logic [15:0] buf_data [SMRS_NUM_BUFS][MSG_WORDS];
	smrs_msg_info_t buf_info [SMRS_NUM_BUFS];
	logic [SMRS_PTR_W-1:0] wr_ptr_reg;
	logic [SMRS_PTR_W-1:0] rd_ptr_reg;
	logic [SMRS_PTR_W-1:0] count_reg;
	logic word_we;
	logic [SMRS_WIDX_W-1:0] word_idx;
	logic [15:0] word_data;
	logic msg_done;
	smrs_msg_info_t msg_info;
	logic full_drop;

	// a message committed this cycle is not yet in the count
	wire bufs_full = (count_reg + SMRS_PTR_W'(msg_done))
		== SMRS_PTR_W'(SMRS_NUM_BUFS);

	smrs_msg_assembler #(.MSG_BYTES(MSG_BYTES)) u_asm (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_char_valid(i_char_valid),
		.i_char(i_char),
		.i_slot_free(~bufs_full),
		.o_word_we(word_we),
		.o_word_idx(word_idx),
		.o_word_data(word_data),
		.o_msg_done(msg_done),
		.o_msg_info(msg_info),
		.o_full_drop(full_drop)
	);

	// storage has no reset: the count says which entries are live
	always_ff @(posedge i_sys_clk)
	begin
		if (word_we)
			buf_data[wr_ptr_reg][word_idx] <= word_data;
		if (msg_done)
			buf_info[wr_ptr_reg] <= msg_info;
	end

	////////////////////////////////////////////////////////////////////////
	// bus decode; every access takes exactly one wait cycle
	logic ack_reg;
	logic [31:0] rdata_reg;
	wire bus_req = i_avs_read | i_avs_write;
	wire bus_done = bus_req & ack_reg;
	wire wr = i_avs_write & bus_done;
	wire rd = i_avs_read & bus_done;
	wire wr_ctrl = wr & (i_avs_address == SMRS_OFS_CTRL);
	wire wr_start = wr & (i_avs_address == SMRS_OFS_START);
	wire wr_lo = wr & (i_avs_address == SMRS_OFS_RANGE_LO);
	wire wr_hi = wr & (i_avs_address == SMRS_OFS_RANGE_HI);
	wire wr_chan = wr & (i_avs_address == SMRS_OFS_CHAN);
	wire wr_mask = wr & (i_avs_address == SMRS_OFS_IRQ_MASK);
	wire rd_irq = rd & (i_avs_address == SMRS_OFS_IRQ_STAT);
	wire go = wr_ctrl & i_avs_byteenable[0]
		& i_avs_writedata[SMRS_CTL_START];
	assign o_avs_waitrequest = bus_req & ~ack_reg;
	assign o_avs_readdata = rdata_reg;

	////////////////////////////////////////////////////////////////////////
	// registers
	smrs_st_t state_reg;
	logic [15:0] ctrl_reg;
	logic [15:0] result_reg;
	logic [15:0] rx_err_reg;
	logic [15:0] size_reg;
	logic [15:0] start_reg;
	logic [15:0] lo_reg;
	logic [15:0] hi_reg;
	logic [15:0] chan_reg;
	logic [3:0] irq_stat_reg;
	logic [3:0] irq_mask_reg;
	logic full_pend_reg;
	logic disc_pend_reg;
	logic [31:0] timer_reg;
	logic [SMRS_WIDX_W-1:0] widx_reg;

	wire busy = state_reg != ST_IDLE;
	wire fd_mode = ctrl_reg[SMRS_CTL_FD];
	wire [15:0] ctrl_view = {ctrl_reg[15:1], busy};
	wire [15:0] rx_err_view = fd_mode ? rx_err_reg : 16'h0000;

	logic [15:0] rd_mux;
	always_comb
	begin
		case (i_avs_address)
			SMRS_OFS_CTRL: rd_mux = ctrl_view;
			SMRS_OFS_RESULT: rd_mux = result_reg;
			SMRS_OFS_RX_ERR: rd_mux = rx_err_view;
			SMRS_OFS_SIZE: rd_mux = size_reg;
			SMRS_OFS_START: rd_mux = start_reg;
			SMRS_OFS_RANGE_LO: rd_mux = lo_reg;
			SMRS_OFS_RANGE_HI: rd_mux = hi_reg;
			SMRS_OFS_CHAN: rd_mux = chan_reg;
			SMRS_OFS_RSVD_A: rd_mux = {11'h000, wr_ptr_reg};
			SMRS_OFS_RSVD_B: rd_mux = {11'h000, count_reg};
			SMRS_OFS_IRQ_STAT: rd_mux = {12'h000, irq_stat_reg};
			SMRS_OFS_IRQ_MASK: rd_mux = {12'h000, irq_mask_reg};
			default: rd_mux = 16'h0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// current message checks
	smrs_msg_info_t head;
	assign head = buf_info[rd_ptr_reg];
	wire [SMRS_CNT_W:0] nb_plus = {1'b0, head.nbytes} + 1'b1;
	wire [SMRS_CNT_W-1:0] nwords = nb_plus[SMRS_CNT_W:1];
	wire [16:0] end_addr = {1'b0, start_reg}
		+ {{(17 - SMRS_CNT_W){1'b0}}, nwords} - 17'h00001;
	wire line_err = head.par_err | head.frm_err | head.ovr_err;
	wire size_bad = head.too_long | (head.nbytes == '0);
	wire range_bad = (start_reg < lo_reg)
		| (end_addr > {1'b0, hi_reg})
		| (end_addr > {1'b0, MEM_MAX_ADDR});
	wire last_word = widx_reg == SMRS_WIDX_W'(nwords - 1'b1);

	wire in_check = state_reg == ST_CHECK;
	wire fail = in_check & (line_err | size_bad | range_bad);
	wire finish = (state_reg == ST_WRITE) & last_word;
	wire timed_out = (state_reg == ST_IDLE) & (count_reg != '0)
		& (timer_reg == 32'(TIMEOUT_CYCLES - 1));
	wire pop = fail | finish | timed_out;
	wire [SMRS_PTR_W-1:0] count_next = count_reg
		+ SMRS_PTR_W'(msg_done) - SMRS_PTR_W'(pop);

	logic [15:0] err_word;
	always_comb
	begin
		err_word = 16'h0000;
		err_word[SMRS_ST_FULL] = full_pend_reg | full_drop;
		err_word[SMRS_ST_DISC] = disc_pend_reg | timed_out;
		err_word[SMRS_ST_PAR] = head.par_err;
		err_word[SMRS_ST_FRM] = head.frm_err;
		err_word[SMRS_ST_OVR] = head.ovr_err;
	end

	wire [7:0] fail_code = line_err ? SMRS_RES_LINE_ERR
		: size_bad ? SMRS_RES_SIZE_ERR : SMRS_RES_ADDR_ERR;
	wire [3:0] irq_set = {timed_out, full_drop, fail, finish};

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			timer_reg <= 32'h00000000;
			full_pend_reg <= 1'b0;
			disc_pend_reg <= 1'b0;
		end
		else
		begin
			ack_reg <= bus_req & ~ack_reg;
			if (bus_req & ~ack_reg)
				rdata_reg <= {16'h0000, rd_mux};
			if (msg_done)
				wr_ptr_reg <= next_ptr(wr_ptr_reg);
			if (pop)
				rd_ptr_reg <= next_ptr(rd_ptr_reg);
			count_reg <= count_next;
			timer_reg <= (pop | (count_reg == '0)) ? 32'h00000000
				: timer_reg + 32'h00000001;
			// a new event in the reporting cycle stays pending
			full_pend_reg <= full_drop | (full_pend_reg & ~in_check);
			disc_pend_reg <= timed_out | (disc_pend_reg & ~in_check);
		end
	end

	// receive function sequencer
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			state_reg <= ST_IDLE;
			result_reg <= SMRS_RESULT_RST;
			rx_err_reg <= SMRS_REG_RST;
			size_reg <= SMRS_REG_RST;
			widx_reg <= '0;
			o_mem_wr <= '0;
		end
		else
		begin
			o_mem_wr.we <= 1'b0;
			case (state_reg)
				ST_IDLE:
				begin
					if (go & start_reg[15])
						result_reg <= {SMRS_RES_ADDR_ERR, 8'h00};
					else if (go)
					begin
						result_reg <= {SMRS_RES_BUSY, 8'h00};
						state_reg <= ST_WAIT;
					end
				end
				ST_WAIT:
				begin
					if (count_reg != '0)
						state_reg <= ST_CHECK;
				end
				ST_CHECK:
				begin
					rx_err_reg <= err_word;
					widx_reg <= '0;
					o_mem_wr.addr <= start_reg;
					if (fail)
					begin
						result_reg <= {fail_code, 8'h00};
						state_reg <= ST_IDLE;
					end
					else
						state_reg <= ST_WRITE;
				end
				ST_WRITE:
				begin
					o_mem_wr.we <= 1'b1;
					o_mem_wr.data <= buf_data[rd_ptr_reg][widx_reg];
					if (o_mem_wr.we)
						o_mem_wr.addr <= o_mem_wr.addr + 16'h0001;
					widx_reg <= widx_reg + 1'b1;
					if (last_word)
					begin
						result_reg <= {SMRS_RES_DONE, 8'h00};
						size_reg <= ctrl_reg[SMRS_CTL_BYTES]
							? {10'h000, head.nbytes}
							: {10'h000, nwords};
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// software registers; device updates win over a same-cycle write
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			ctrl_reg <= SMRS_REG_RST;
			start_reg <= SMRS_REG_RST;
			lo_reg <= SMRS_REG_RST;
			hi_reg <= SMRS_REG_RST;
			chan_reg <= SMRS_REG_RST;
			irq_mask_reg <= SMRS_IRQ_RST;
			irq_stat_reg <= SMRS_IRQ_RST;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_reg <= be_merge(ctrl_reg, i_avs_writedata,
					i_avs_byteenable) & 16'h0006;
			if (wr_start)
				start_reg <= be_merge(start_reg, i_avs_writedata,
					i_avs_byteenable);
			if (wr_lo)
				lo_reg <= be_merge(lo_reg, i_avs_writedata, i_avs_byteenable);
			if (wr_hi)
				hi_reg <= be_merge(hi_reg, i_avs_writedata, i_avs_byteenable);
			if ((state_reg == ST_WAIT) & (count_reg != '0))
				chan_reg <= {11'h000, rd_ptr_reg};
			else if (wr_chan)
				chan_reg <= be_merge(chan_reg, i_avs_writedata,
					i_avs_byteenable);
			if (wr_mask & i_avs_byteenable[0])
				irq_mask_reg <= i_avs_writedata[3:0];
			// only bits already captured for the reader are cleared, so an
			// event landing during the wait cycle is not lost
			irq_stat_reg <= irq_set
				| (irq_stat_reg & ~(rdata_reg[3:0] & {4{rd_irq}}));
		end
	end

	assign o_irq = |(irq_stat_reg & irq_mask_reg);

endmodule
